// [hw/sfrbk_pkg.sv]
// Package holding offsets, field positions, reset values and codes of the SFR bank.
package sfrbk_pkg;

  // Register addresses in the data-memory map.
  localparam logic [7:0] ADDR_ANALOG_PAD_SELECT    = 8'h16;
  localparam logic [7:0] ADDR_ADC_OFFSET_TRIM      = 8'h17;
  localparam logic [7:0] ADDR_EXT_IRQ_EDGE_CONFIG  = 8'h18;
  localparam logic [7:0] ADDR_TIMER_PWM_HIGH_BITS  = 8'h19;
  localparam logic [7:0] ADDR_ANALOG_BLOCK_ENABLE  = 8'h1A;
  localparam logic [7:0] ADDR_RFC_PAD_CONTROL      = 8'h1B;
  localparam logic [7:0] ADDR_TIMER3_PWM_HIGH_BITS = 8'h1C;
  localparam logic [7:0] ADDR_SECOND_IRQ_ENABLE    = 8'h1F;

  // Field positions.
  localparam int TRIM_POLARITY_BIT   = 5;
  localparam int PIN1_ROUTE_BIT      = 5;
  localparam int PIN0_ROUTE_BIT      = 4;
  localparam int IRQ1_EDGE_LSB       = 2;
  localparam int IRQ0_EDGE_LSB       = 0;
  localparam int T2_MSB_LSB          = 6;
  localparam int T1_MSB_LSB          = 4;
  localparam int T3_MSB_LSB          = 4;
  localparam int CH_HI_LSB           = 2;
  localparam int ENABLE_BIT7         = 7;
  localparam int T3_FLAG_BIT         = 4;
  localparam int T3_ENABLE_BIT       = 0;
  localparam int MODE_SLOW_OSC_BIT   = 7;
  localparam int MODE_SPARE_BIT      = 6;
  localparam int MODE_SOURCE_BIT     = 5;
  localparam int MODE_EDGE_BIT       = 4;
  localparam int MODE_OWNER_BIT      = 3;

  // Reset values; bits shown unknown in the map reset to zero here.
  localparam logic [7:0] RST_ANALOG_PAD_SELECT = 8'h00;
  localparam logic [5:0] RST_ADC_OFFSET_TRIM   = 6'h00;
  localparam logic [5:0] RST_EXT_IRQ_EDGE      = 6'h05;
  localparam logic [7:0] RST_TIMER_PWM_HIGH    = 8'h00;
  localparam logic [5:0] RST_TIMER3_PWM_HIGH   = 6'h00;
  localparam logic [4:0] RST_RFC_PAD_CONTROL   = 5'h00;
  localparam logic [7:0] RST_TICK_MODE         = 8'h3F;
  localparam logic [3:0] RST_DIV_LOG2          = 4'h8;

  // Edge field codes.
  typedef enum logic [1:0]
  {
    SFRBK_EDGE_NONE    = 2'b00,
    SFRBK_EDGE_RISING  = 2'b01,
    SFRBK_EDGE_FALLING = 2'b10,
    SFRBK_EDGE_BOTH    = 2'b11
  } sfrbk_edge_t;

  // Tick source choices.
  typedef enum logic [1:0]
  {
    SFRBK_SRC_INSTR = 2'b00,
    SFRBK_SRC_PIN   = 2'b01,
    SFRBK_SRC_SLOW  = 2'b10
  } sfrbk_src_t;

endpackage : sfrbk_pkg

// [hw/sfrbk_edge_irq.sv]
// Synchronised external interrupt pad with edge qualification.
`timescale 1ns/1ps
`default_nettype none
module sfrbk_edge_irq
  import sfrbk_pkg::*;
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        resetn,
  // Pad and configuration.
  input  wire logic        pad_in,
  input  wire logic        route_en,
  input  wire logic [1:0]  edge_sel,
  // Request.
  output logic             irq_pulse
);

  typedef struct packed
  {
    logic meta;
    logic sync;
    logic prev;
    logic irq;
  } sfrbk_edge_st_t;

  sfrbk_edge_st_t s_q;
  sfrbk_edge_st_t s_d;

  always_comb
  begin
    s_d      = s_q;
    s_d.meta = pad_in;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
    s_d.irq  = 1'b0;
    if (route_en)
    begin
      case (sfrbk_edge_t'(edge_sel))
        SFRBK_EDGE_RISING:  s_d.irq = s_q.sync & ~s_q.prev;
        SFRBK_EDGE_FALLING: s_d.irq = ~s_q.sync & s_q.prev;
        SFRBK_EDGE_BOTH:    s_d.irq = s_q.sync ^ s_q.prev;
        default:            s_d.irq = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign irq_pulse = s_q.irq;

endmodule : sfrbk_edge_irq
`default_nettype wire

// [hw/sfrbk_prescale_decode.sv]
// Decoder of the shared prescaler rate into a divide exponent.
`timescale 1ns/1ps
`default_nettype none
module sfrbk_prescale_decode
  import sfrbk_pkg::*;
(
  // Mode fields.
  input  wire logic [2:0]  rate_code,
  input  wire logic        owner_wdt,
  input  wire logic        wdt_reset_mode,
  // Divide by two to the power of this value.
  output logic [3:0]       div_log2
);

  always_comb
  begin
    if (owner_wdt && wdt_reset_mode)
      div_log2 = {1'b0, rate_code};
    else
      div_log2 = {1'b0, rate_code} + 4'h1;
  end

endmodule : sfrbk_prescale_decode
`default_nettype wire

// [hw/sfrbk_bank.sv]
// Special function register bank for analog pads, external interrupts and timer high bits.
`timescale 1ns/1ps
`default_nettype none
module sfrbk_bank
  import sfrbk_pkg::*;
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        resetn,
  // Data-memory access from the core.
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  // Dedicated mode register instructions.
  input  wire logic        mode_reg_write_instr,
  input  wire logic        mode_reg_read_instr,
  output logic      [7:0]  mode_rdata,
  // Pads.
  input  wire logic [7:0]  porta_pad_in,
  input  wire logic [5:0]  portb_pad_in,
  output logic      [7:0]  porta_digital_in,
  output logic      [5:0]  portb_digital_in,
  output logic      [4:0]  porta_analog_only,
  output logic      [2:0]  portb_analog_only,
  // Timers and PWM.
  input  wire logic [9:0]  t1_count,
  input  wire logic [9:0]  t2_count,
  input  wire logic [9:0]  t3_count,
  input  wire logic        t3_underflow,
  output logic      [1:0]  t1_reload_msbs,
  output logic      [1:0]  t2_reload_msbs,
  output logic      [1:0]  t3_reload_msbs,
  output logic             t1_reload_load,
  output logic             t2_reload_load,
  output logic             t3_reload_load,
  output logic      [1:0]  ch1_duty_msbs,
  output logic      [1:0]  ch2_duty_msbs,
  output logic      [1:0]  ch3_duty_msbs,
  output logic      [1:0]  ch4_duty_msbs,
  output logic             t3_irq_req,
  // Analog controls.
  output logic      [4:0]  trim_magnitude,
  output logic             trim_polarity,
  output logic             comparator_on,
  output logic             rc_measure_on,
  output logic      [3:0]  rc_pad_code,
  // External interrupts.
  output logic             irq0_req,
  output logic             irq1_req,
  output logic             pin0_irq_route,
  output logic             pin1_irq_route,
  // Timer0 and watchdog prescaler.
  input  wire logic        wdt_reset_mode,
  output logic             prescale_owner,
  output logic      [2:0]  prescale_rate_code,
  output logic      [3:0]  prescale_div_log2,
  output logic      [1:0]  tick_source,
  output logic             tick_edge_select
);

  typedef struct packed
  {
    logic [7:0] pad_sel;
    logic [5:0] trim;
    logic [5:0] edge_cfg;
    logic [7:0] tmr_hi;
    logic       cmp_en;
    logic [4:0] rfc_pad_control;
    logic [5:0] tmr3_hi;
    logic       t3_flag;
    logic       t3_en;
    logic [7:0] mode;
    logic [7:0] rdata;
    logic [7:0] mrdata;
    logic [7:0] pa_meta;
    logic [7:0] pa_sync;
    logic [5:0] pb_meta;
    logic [5:0] pb_sync;
    logic [7:0] pa_dig;
    logic [5:0] pb_dig;
    logic [2:0] loads;
    logic       t3_irq;
    logic [3:0] div_log2;
    logic [1:0] src;
  } sfrbk_st_t;

  sfrbk_st_t s_q;
  sfrbk_st_t s_d;

  logic       irq0_w;
  logic       irq1_w;
  logic [3:0] div_w;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit

  // Each interrupt pad has its own synchroniser, so request timing never depends on the GPIO path.
  sfrbk_edge_irq u_irq0
  (
    .clock     (clock),
    .resetn    (resetn),
    .pad_in    (portb_pad_in[0]),
    .route_en  (s_q.edge_cfg[PIN0_ROUTE_BIT]),
    .edge_sel  (s_q.edge_cfg[IRQ0_EDGE_LSB +: 2]),
    .irq_pulse (irq0_w)
  );

  sfrbk_edge_irq u_irq1
  (
    .clock     (clock),
    .resetn    (resetn),
    .pad_in    (portb_pad_in[1]),
    .route_en  (s_q.edge_cfg[PIN1_ROUTE_BIT]),
    .edge_sel  (s_q.edge_cfg[IRQ1_EDGE_LSB +: 2]),
    .irq_pulse (irq1_w)
  );

  sfrbk_prescale_decode u_pre
  (
    .rate_code      (s_q.mode[2:0]),
    .owner_wdt      (s_q.mode[MODE_OWNER_BIT]),
    .wdt_reset_mode (wdt_reset_mode),
    .div_log2       (div_w)
  );

  always_comb
  begin
    s_d       = s_q;
    s_d.loads = 3'b000;
    // Pads are synchronised before reaching the digital input path.
    s_d.pa_meta = porta_pad_in;
    s_d.pa_sync = s_q.pa_meta;
    s_d.pb_meta = portb_pad_in;
    s_d.pb_sync = s_q.pb_meta;
    s_d.pa_dig  = s_q.pa_sync & ~{3'b000, s_q.pad_sel[4:0]};
    s_d.pb_dig  = s_q.pb_sync & ~{3'b000, s_q.pad_sel[7:5]};
    // Interrupt routing means the pad is no GPIO input any more.
    if (s_q.edge_cfg[PIN0_ROUTE_BIT])
      s_d.pb_dig[0] = 1'b0;
    if (s_q.edge_cfg[PIN1_ROUTE_BIT])
      s_d.pb_dig[1] = 1'b0;

    if (sfr_wr)
    begin
      if (hit(sfr_addr, ADDR_ANALOG_PAD_SELECT))
        s_d.pad_sel = sfr_wdata;
      if (hit(sfr_addr, ADDR_ADC_OFFSET_TRIM))
        s_d.trim = sfr_wdata[5:0];
      if (hit(sfr_addr, ADDR_EXT_IRQ_EDGE_CONFIG))
        s_d.edge_cfg = sfr_wdata[5:0];
      if (hit(sfr_addr, ADDR_TIMER_PWM_HIGH_BITS))
      begin
        s_d.tmr_hi = sfr_wdata;
        s_d.loads[0] = 1'b1;
        s_d.loads[1] = 1'b1;
      end
      if (hit(sfr_addr, ADDR_ANALOG_BLOCK_ENABLE))
        s_d.cmp_en = sfr_wdata[ENABLE_BIT7];
      if (hit(sfr_addr, ADDR_RFC_PAD_CONTROL))
        s_d.rfc_pad_control = {sfr_wdata[ENABLE_BIT7], sfr_wdata[3:0]};
      if (hit(sfr_addr, ADDR_TIMER3_PWM_HIGH_BITS))
      begin
        s_d.tmr3_hi = sfr_wdata[5:0];
        s_d.loads[2] = 1'b1;
      end
      if (hit(sfr_addr, ADDR_SECOND_IRQ_ENABLE))
      begin
        s_d.t3_en   = sfr_wdata[T3_ENABLE_BIT];
        s_d.t3_flag = sfr_wdata[T3_FLAG_BIT];
      end
    end
    // A simultaneous underflow wins over a firmware clear.
    if (t3_underflow)
      s_d.t3_flag = 1'b1;
    s_d.t3_irq = s_q.t3_flag & s_q.t3_en;

    // The mode register has no data address; only its instructions reach it.
    if (mode_reg_write_instr)
      s_d.mode = sfr_wdata;
    if (mode_reg_read_instr)
      s_d.mrdata = s_q.mode;
    s_d.div_log2 = div_w;
    if (!s_q.mode[MODE_SOURCE_BIT])
      s_d.src = SFRBK_SRC_INSTR;
    else if (s_q.mode[MODE_SLOW_OSC_BIT])
      s_d.src = SFRBK_SRC_SLOW;
    else
      s_d.src = SFRBK_SRC_PIN;

    // Unmapped addresses read zero; reads have no side effect.
    s_d.rdata = 8'h00;
    if (sfr_rd)
    begin
      case (sfr_addr)
        ADDR_ANALOG_PAD_SELECT:    s_d.rdata = s_q.pad_sel;
        ADDR_ADC_OFFSET_TRIM:      s_d.rdata = {2'b00, s_q.trim};
        ADDR_EXT_IRQ_EDGE_CONFIG:  s_d.rdata = {2'b00, s_q.edge_cfg};
        ADDR_TIMER_PWM_HIGH_BITS:  s_d.rdata = {t2_count[9:8], t1_count[9:8],
                                                s_q.tmr_hi[3:0]};
        ADDR_ANALOG_BLOCK_ENABLE:  s_d.rdata = {s_q.cmp_en, 7'h00};
        ADDR_RFC_PAD_CONTROL:      s_d.rdata = {s_q.rfc_pad_control[4], 3'b000, s_q.rfc_pad_control[3:0]};
        ADDR_TIMER3_PWM_HIGH_BITS: s_d.rdata = {2'b00, t3_count[9:8],
                                                s_q.tmr3_hi[3:0]};
        ADDR_SECOND_IRQ_ENABLE:    s_d.rdata = {3'b000, s_q.t3_flag, 3'b000, s_q.t3_en};
        default:                   s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q          <= '0;
      s_q.pad_sel  <= RST_ANALOG_PAD_SELECT;
      s_q.trim     <= RST_ADC_OFFSET_TRIM;
      s_q.edge_cfg <= RST_EXT_IRQ_EDGE;
      s_q.tmr_hi   <= RST_TIMER_PWM_HIGH;
      s_q.rfc_pad_control      <= RST_RFC_PAD_CONTROL;
      s_q.tmr3_hi  <= RST_TIMER3_PWM_HIGH;
      s_q.mode     <= RST_TICK_MODE;
      // Derived outputs start from the reset mode so they agree with it before the first edge; div_log2 agrees only while wdt_reset_mode is low.
      s_q.div_log2 <= RST_DIV_LOG2;
      s_q.src      <= SFRBK_SRC_PIN;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sfr_rdata          = s_q.rdata;
  assign mode_rdata         = s_q.mrdata;
  assign porta_digital_in   = s_q.pa_dig;
  assign portb_digital_in   = s_q.pb_dig;
  assign porta_analog_only  = s_q.pad_sel[4:0];
  assign portb_analog_only  = s_q.pad_sel[7:5];
  assign t2_reload_msbs     = s_q.tmr_hi[T2_MSB_LSB +: 2];
  assign t1_reload_msbs     = s_q.tmr_hi[T1_MSB_LSB +: 2];
  assign t3_reload_msbs     = s_q.tmr3_hi[T3_MSB_LSB +: 2];
  assign t1_reload_load     = s_q.loads[0];
  assign t2_reload_load     = s_q.loads[1];
  assign t3_reload_load     = s_q.loads[2];
  assign ch1_duty_msbs      = s_q.tmr_hi[1:0];
  assign ch2_duty_msbs      = s_q.tmr_hi[CH_HI_LSB +: 2];
  assign ch3_duty_msbs      = s_q.tmr3_hi[1:0];
  assign ch4_duty_msbs      = s_q.tmr3_hi[CH_HI_LSB +: 2];
  assign t3_irq_req         = s_q.t3_irq;
  assign trim_magnitude     = s_q.trim[4:0];
  assign trim_polarity      = s_q.trim[TRIM_POLARITY_BIT];
  assign comparator_on      = s_q.cmp_en;
  assign rc_measure_on      = s_q.rfc_pad_control[4];
  assign rc_pad_code        = s_q.rfc_pad_control[3:0];
  assign pin0_irq_route     = s_q.edge_cfg[PIN0_ROUTE_BIT];
  assign pin1_irq_route     = s_q.edge_cfg[PIN1_ROUTE_BIT];
  assign irq0_req           = irq0_w;
  assign irq1_req           = irq1_w;
  assign prescale_owner     = s_q.mode[MODE_OWNER_BIT];
  assign prescale_rate_code = s_q.mode[2:0];
  assign prescale_div_log2  = s_q.div_log2;
  assign tick_source        = s_q.src;
  assign tick_edge_select   = s_q.mode[MODE_EDGE_BIT];

endmodule : sfrbk_bank
`default_nettype wire

// [tb/sfrbk_bank_props.sv]
// Concurrent checks on the ports of the SFR bank, bound onto the bank.
`timescale 1ns/1ps
`default_nettype none
module sfrbk_bank_props
  import sfrbk_pkg::*;
(
  // Clock and reset.
  input wire logic       clock,
  input wire logic       resetn,
  // Core access.
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       mode_reg_write_instr,
  // Timers, pads and controls.
  input wire logic [9:0] t1_count,
  input wire logic [9:0] t2_count,
  input wire logic [9:0] t3_count,
  input wire logic [4:0] porta_analog_only,
  input wire logic [2:0] portb_analog_only,
  input wire logic [1:0] t1_reload_msbs,
  input wire logic [1:0] t2_reload_msbs,
  input wire logic       t1_reload_load,
  input wire logic       t2_reload_load,
  input wire logic       t3_reload_load,
  input wire logic       t3_irq_req,
  input wire logic       rc_measure_on,
  input wire logic [3:0] rc_pad_code,
  input wire logic       irq0_req,
  input wire logic       irq1_req,
  input wire logic       pin0_irq_route,
  input wire logic       pin1_irq_route,
  input wire logic       wdt_reset_mode,
  input wire logic       prescale_owner,
  input wire logic [2:0] prescale_rate_code,
  input wire logic [3:0] prescale_div_log2
);
  wire logic wr_pad = sfr_wr && sfr_addr == ADDR_ANALOG_PAD_SELECT;
  wire logic wr_tmr = sfr_wr && sfr_addr == ADDR_TIMER_PWM_HIGH_BITS;
  wire logic wr_tm3 = sfr_wr && sfr_addr == ADDR_TIMER3_PWM_HIGH_BITS;
  wire logic wr_rfc = sfr_wr && sfr_addr == ADDR_RFC_PAD_CONTROL;
  wire logic wr_ir2 = sfr_wr && sfr_addr == ADDR_SECOND_IRQ_ENABLE;
  wire logic rd_tmr = sfr_rd && sfr_addr == ADDR_TIMER_PWM_HIGH_BITS;
  wire logic rd_tm3 = sfr_rd && sfr_addr == ADDR_TIMER3_PWM_HIGH_BITS;
  wire logic rd_bad = sfr_rd && !(sfr_addr inside {[8'h16:8'h1C], ADDR_SECOND_IRQ_ENABLE});

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_pads; wr_pad |=> {portb_analog_only, porta_analog_only} == $past(sfr_wdata); endproperty
  a_pads: assert property (p_pads) else $error("pad select outputs differ from write");
  property p_bad_rd; rd_bad |=> sfr_rdata == 8'h00; endproperty
  a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not zero");
  property p_tmr_wr;
    wr_tmr |=> t1_reload_load && t2_reload_load &&
      {t2_reload_msbs, t1_reload_msbs} == $past(sfr_wdata[7:4]);
  endproperty
  a_tmr_wr: assert property (p_tmr_wr) else $error("timer reload bits not loaded");
  property p_tmr_rd; rd_tmr |=> sfr_rdata[7:4] == {$past(t2_count[9:8]), $past(t1_count[9:8])};
  endproperty
  a_tmr_rd: assert property (p_tmr_rd) else $error("timer high read not live count");
  property p_tm3_wr;
    wr_tm3 |=> t3_reload_load ##1 (t3_reload_load == $past(wr_tm3));
  endproperty
  a_tm3_wr: assert property (p_tm3_wr) else $error("timer3 load pulse wrong");
  property p_tm3_rd; rd_tm3 |=> sfr_rdata[7:4] == {2'b00, $past(t3_count[9:8])}; endproperty
  a_tm3_rd: assert property (p_tm3_rd) else $error("timer3 high read not live count");
  property p_hold; $fell(t3_irq_req) |-> $past(wr_ir2) || $past(wr_ir2, 2); endproperty
  a_hold: assert property (p_hold) else $error("timer3 request fell without write");
  property p_r0; !pin0_irq_route [*4] |-> !irq0_req; endproperty
  a_r0: assert property (p_r0) else $error("irq0 while pad is gpio");
  property p_r1; !pin1_irq_route [*4] |-> !irq1_req; endproperty
  a_r1: assert property (p_r1) else $error("irq1 while pad is gpio");
  property p_rfc;
    wr_rfc |=> rc_measure_on == $past(sfr_wdata[7]) && rc_pad_code == $past(sfr_wdata[3:0]);
  endproperty
  a_rfc: assert property (p_rfc) else $error("rfc controls differ from write");
  // The watchdog mode input reaches the divide through a register, so it must hold while the fields settle.
  property p_div;
    mode_reg_write_instr ##1 (!mode_reg_write_instr && $stable(wdt_reset_mode)) [*3] |->
      prescale_div_log2 == {1'b0, prescale_rate_code} + (prescale_owner && wdt_reset_mode ? 0 : 1);
  endproperty
  a_div: assert property (p_div) else $error("prescale divide wrong");
  c_irq0: cover property (irq0_req);
  c_t3: cover property ($rose(t3_irq_req));
  c_rd: cover property (rd_tmr);
  c_mode: cover property (mode_reg_write_instr);
endmodule : sfrbk_bank_props

bind sfrbk_bank sfrbk_bank_props u_props (.clock, .resetn, .sfr_addr, .sfr_wr, .sfr_rd,
  .sfr_wdata, .sfr_rdata, .mode_reg_write_instr, .t1_count, .t2_count, .t3_count,
  .porta_analog_only, .portb_analog_only, .t1_reload_msbs, .t2_reload_msbs, .t1_reload_load,
  .t2_reload_load, .t3_reload_load, .t3_irq_req, .rc_measure_on, .rc_pad_code, .irq0_req, .irq1_req,
  .pin0_irq_route, .pin1_irq_route, .wdt_reset_mode, .prescale_owner, .prescale_rate_code,
  .prescale_div_log2);
`default_nettype wire

// [tb/sfr_bank_adc_pin_edge_timer_ext_bench.sv]
// Self-checking bench of the SFR bank.
`timescale 1ns/1ps
`default_nettype none
module sfr_bank_adc_pin_edge_timer_ext_bench;
  import sfrbk_pkg::*;
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
  logic       clock, resetn, sfr_wr, sfr_rd, mode_reg_write_instr, mode_reg_read_instr;
  logic       t3_underflow, wdt_reset_mode, t1_reload_load, t2_reload_load, t3_reload_load;
  logic       t3_irq_req, trim_polarity, comparator_on, rc_measure_on, irq0_req, irq1_req;
  logic       pin0_irq_route, pin1_irq_route, prescale_owner, tick_edge_select;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, mode_rdata, porta_pad_in, porta_digital_in, rv;
  logic [5:0] portb_pad_in, portb_digital_in;
  logic [4:0] porta_analog_only, trim_magnitude;
  logic [2:0] portb_analog_only, prescale_rate_code;
  logic [9:0] t1_count, t2_count, t3_count;
  logic [1:0] t1_reload_msbs, t2_reload_msbs, t3_reload_msbs, ch1_duty_msbs, ch2_duty_msbs;
  logic [1:0] ch3_duty_msbs, ch4_duty_msbs, tick_source;
  logic [3:0] rc_pad_code, prescale_div_log2;
  int         num_errors, check_count, cycles, n0, n1;

  sfrbk_bank uut (.clock, .resetn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .mode_reg_write_instr, .mode_reg_read_instr, .mode_rdata, .porta_pad_in, .portb_pad_in,
    .porta_digital_in, .portb_digital_in, .porta_analog_only, .portb_analog_only,
    .t1_count, .t2_count, .t3_count, .t3_underflow, .t1_reload_msbs, .t2_reload_msbs,
    .t3_reload_msbs, .t1_reload_load, .t2_reload_load, .t3_reload_load, .ch1_duty_msbs,
    .ch2_duty_msbs, .ch3_duty_msbs, .ch4_duty_msbs, .t3_irq_req, .trim_magnitude,
    .trim_polarity, .comparator_on, .rc_measure_on, .rc_pad_code, .irq0_req, .irq1_req,
    .pin0_irq_route, .pin1_irq_route, .wdt_reset_mode, .prescale_owner, .prescale_rate_code,
    .prescale_div_log2, .tick_source, .tick_edge_select);

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Pulses are counted on the edge itself, so each one-cycle pulse is seen exactly once.
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (irq0_req) n0 <= n0 + 1;
    if (irq1_req) n1 <= n1 + 1;
    if (cycles == 5000)
    begin
      num_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
    @(negedge clock);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(negedge clock);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clock);
    sfr_rd = 1'b0;
    rv = sfr_rdata;
  endtask : rd

  task automatic mwr(input logic [7:0] d);
    @(negedge clock);
    sfr_wdata = d;
    mode_reg_write_instr = 1'b1;
    @(negedge clock);
    mode_reg_write_instr = 1'b0;
    mode_reg_read_instr = 1'b1;
    @(negedge clock);
    mode_reg_read_instr = 1'b0;
    repeat (2) @(negedge clock);
  endtask : mwr

  task automatic t_reset();
    `CHK("pad_rst", 8'h00, {portb_analog_only, porta_analog_only})
    `CHK("cmp_rst", 1'b0, comparator_on)
    `CHK("div_rst", 4'h8, prescale_div_log2)
    `CHK("src_rst", 2'b01, tick_source)
    rd(ADDR_EXT_IRQ_EDGE_CONFIG);
    `CHK("edge_rst", 8'h05, rv)
    rd(ADDR_SECOND_IRQ_ENABLE);
    `CHK("irq2_rst", 8'h00, rv)
    $display("t_reset done");
  endtask : t_reset

  task automatic t_regs();
    porta_pad_in = 8'hFF;
    portb_pad_in = 6'h3F;
    wr(ADDR_ANALOG_PAD_SELECT, 8'hB5);
    repeat (3) @(negedge clock);
    `CHK("pa_only", 5'h15, porta_analog_only)
    `CHK("pb_only", 3'h5, portb_analog_only)
    `CHK("pa_dig", 8'hEA, porta_digital_in)
    `CHK("pb_dig", 6'h3A, portb_digital_in)
    rd(ADDR_ANALOG_PAD_SELECT);
    `CHK("pad_rd", 8'hB5, rv)
    wr(ADDR_ADC_OFFSET_TRIM, 8'hDA);
    rd(ADDR_ADC_OFFSET_TRIM);
    `CHK("trim_rd", 8'h1A, rv)
    `CHK("trim", 6'h1A, {trim_polarity, trim_magnitude})
    wr(ADDR_ANALOG_BLOCK_ENABLE, 8'hFF);
    rd(ADDR_ANALOG_BLOCK_ENABLE);
    `CHK("cmp_rd", 8'h80, rv)
    wr(ADDR_ANALOG_BLOCK_ENABLE, 8'h7F);
    `CHK("cmp_off", 1'b0, comparator_on)
    for (int i = 0; i < 14; i++)
    begin
      wr(ADDR_RFC_PAD_CONTROL, {i[0], 3'b111, i[3:0]});
      rd(ADDR_RFC_PAD_CONTROL);
      `CHK("rfc_rd", {i[0], 3'b000, i[3:0]}, rv)
      `CHK("rfc", {i[0], i[3:0]}, {rc_measure_on, rc_pad_code})
    end
    for (int a = 8'h1D; a < 8'h1F; a++)
    begin
      wr(8'(a), 8'hFF);
      rd(8'(a));
      `CHK("unmapped", 8'h00, rv)
    end
    $display("t_regs done");
  endtask : t_regs

  task automatic t_timer();
    t1_count = 10'h2AA;
    t2_count = 10'h155;
    t3_count = 10'h3FF;
    wr(ADDR_TIMER_PWM_HIGH_BITS, 8'h93);
    `CHK("tmr_wr", 8'h93, {t2_reload_msbs, t1_reload_msbs, ch2_duty_msbs, ch1_duty_msbs})
    rd(ADDR_TIMER_PWM_HIGH_BITS);
    `CHK("tmr_rd", 8'h63, rv)
    wr(ADDR_TIMER3_PWM_HIGH_BITS, 8'hE6);
    `CHK("tm3_wr", 6'h26, {t3_reload_msbs, ch4_duty_msbs, ch3_duty_msbs})
    rd(ADDR_TIMER3_PWM_HIGH_BITS);
    `CHK("tm3_rd", 8'h36, rv)
    $display("t_timer done");
  endtask : t_timer

  task automatic t_irq();
    for (int e = 1; e >= 0; e--)
    begin
      wr(ADDR_SECOND_IRQ_ENABLE, {7'h00, e[0]});
      t3_underflow = 1'b1;
      @(negedge clock);
      t3_underflow = 1'b0;
      repeat (12) @(negedge clock);
      `CHK("t3_req", e[0], t3_irq_req)
      rd(ADDR_SECOND_IRQ_ENABLE);
      `CHK("t3_flag", {3'b000, 1'b1, 3'b000, e[0]}, rv)
    end
    // A clear and an underflow in one cycle: the underflow must win.
    @(negedge clock);
    sfr_addr = ADDR_SECOND_IRQ_ENABLE;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b1;
    t3_underflow = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
    t3_underflow = 1'b0;
    rd(ADDR_SECOND_IRQ_ENABLE);
    `CHK("t3_set_wins", 8'h10, rv)
    wr(ADDR_SECOND_IRQ_ENABLE, 8'h01);
    rd(ADDR_SECOND_IRQ_ENABLE);
    `CHK("t3_clr", 8'h01, rv)
    `CHK("t3_req_clr", 1'b0, t3_irq_req)
    $display("t_irq done");
  endtask : t_irq

  task automatic t_edge();
    int exp [5] = '{0, 1, 1, 2, 0};
    portb_pad_in = 6'h00;
    for (int i = 0; i < 5; i++)
    begin
      wr(ADDR_EXT_IRQ_EDGE_CONFIG, (i < 4) ? {4'h3, i[1:0], i[1:0]} : 8'h0F);
      repeat (6) @(negedge clock);
      n0 = 0;
      n1 = 0;
      portb_pad_in[1:0] = 2'b11;
      repeat (8) @(negedge clock);
      `CHK("pb_gpio", (i < 4) ? 2'b00 : 2'b10, portb_digital_in[1:0])
      `CHK("route", (i < 4) ? 2'b11 : 2'b00, {pin1_irq_route, pin0_irq_route})
      portb_pad_in[1:0] = 2'b00;
      repeat (8) @(negedge clock);
      `CHK("irq0_n", exp[i], n0)
      `CHK("irq1_n", exp[i], n1)
    end
    $display("t_edge done");
  endtask : t_edge

  task automatic t_mode();
    logic [7:0] m;
    for (int i = 0; i < 8; i++)
    begin
      wdt_reset_mode = i[1];
      m = {i[2], 1'b0, i != 3, i[1], i[0], i[2:0]};
      mwr(m);
      `CHK("edge_sel", i[1], tick_edge_select)
      `CHK("mode_rd", m, mode_rdata)
      `CHK("owner", {i[0], i[2:0]}, {prescale_owner, prescale_rate_code})
      `CHK("div", 4'((i[0] && i[1]) ? i[2:0] : i[2:0] + 1), prescale_div_log2)
      `CHK("src", (i == 3) ? 2'b00 : {i[2], !i[2]}, tick_source)
    end
    $display("t_mode done");
  endtask : t_mode

  initial
  begin
    num_errors = 0;
    check_count = 0;
    cycles = 0;
    n0 = 0;
    n1 = 0;
    resetn = 1'b0;
    {sfr_wr, sfr_rd, mode_reg_write_instr, mode_reg_read_instr, t3_underflow} = '0;
    wdt_reset_mode = 1'b0;
    {sfr_addr, sfr_wdata, porta_pad_in, portb_pad_in} = '0;
    {t1_count, t2_count, t3_count} = '0;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    t_reset();
    t_regs();
    t_timer();
    t_irq();
    t_edge();
    t_mode();
    summarize();
  end
endmodule : sfr_bank_adc_pin_edge_timer_ext_bench
`default_nettype wire
